/* File: rtl/card_interface_block.sv */
`timescale 1ns/1ps
module card_interface_block #(
  parameter int ETU_W = 11,
  parameter int GUARD_W = 9
) (
  input wire logic clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable; low freezes the block.
  input wire logic cardClk, // Card clock; paces the link logic.
  input wire logic softReset, // Block reset from software.
  input wire logic manualMode, // High selects manual I/O mode.
  input wire logic manualIoValue, // Line value in manual mode.
  input wire logic invertData, // Invert serial values.
  input wire logic msbFirst, // Send and receive most significant bit first.
  input wire logic [ETU_W-1:0] etuValue, // Time unit length in card clocks.
  input wire logic etuComp, // Half-cycle compensation.
  input wire logic [GUARD_W-1:0] guardTime, // Least start-to-start spacing.
  input wire logic waitEnable, // Waiting counter enable.
  input wire logic [7:0] waitMid, // Middle waiting-time byte.
  input wire logic [7:0] waitLow, // Low waiting-time byte.
  input wire logic waitTopWr, // Write strobe of the top waiting byte.
  input wire logic [7:0] waitTopData, // Top waiting byte value.
  input wire logic txWr, // Transmit buffer write strobe.
  input wire logic [7:0] txData, // Character to send.
  output logic txFull, // Transmit buffer holds a character.
  input wire logic rxRd, // Receive buffer read strobe.
  output logic [7:0] rxData, // Last received character.
  output logic rxValid, // Receive buffer holds a character.
  input wire logic intRead, // Interrupt status read strobe.
  input wire logic [7:0] intEnable, // Mask of events that raise the interrupt.
  output logic [7:0] intStatus, // Sticky event flags.
  output logic irq, // Block interrupt, active high.
  input wire logic powerOnReq, // Request to power the card.
  input wire logic cardResetCtl, // Card reset line level while powered.
  input wire logic presActiveHigh, // Presence pin polarity.
  input wire logic cardPresentPin, // Card presence switch.
  input wire logic ioIn, // Card I/O line level.
  output logic ioOut, // Card I/O drive value.
  output logic ioOe, // Card I/O drive enable.
  output logic cardVccEn, // Card supply enable.
  output logic cardClkEn, // Card clock enable.
  output logic cardResetOut // Card reset line.
);

  // Widths the counters cannot serve are refused at elaboration.
  if (ETU_W < 3 || ETU_W > 16 || GUARD_W < 1) begin : gBadParam
    $error("card_interface_block: unsupported counter width");
  end

  // System clock state.
  typedef struct packed {
    logic blkRst; // Combined reset carried into the card domain.
    logic presS1; // Presence synchroniser, first stage.
    logic presS2; // Presence synchroniser, second stage.
    logic presPrev; // Last synchronised presence.
    logic ackS1; // Transmit acknowledge toggle, first stage.
    logic ackS2; // Transmit acknowledge toggle, second stage.
    logic evS1; // Event toggle, first stage.
    logic evS2; // Event toggle, second stage.
    logic evSeen; // Last event toggle handled.
    logic txReq; // Transmit request toggle.
    logic txFull; // Transmit buffer occupied.
    logic [7:0] txBuf; // Transmit buffer.
    logic [7:0] rxBuf; // Receive buffer.
    logic rxValid; // Receive buffer occupied.
    logic [7:0] waitTop; // Top waiting-time byte.
    logic ldTog; // Wait counter load toggle.
    logic [7:0] intStatus; // Sticky event flags.
    logic [7:0] intPend; // Events caught during a status read.
    logic irq; // Interrupt line.
    card_if_pkg::pwr_state_t pwr; // Card power state.
    logic [1:0] stage; // Deactivation stage.
    logic [card_if_pkg::STEP_W-1:0] stepCnt; // Cycles within a stage.
    logic vccEn; // Supply on.
    logic clkEn; // Card clock on.
    logic rstLvl; // Card reset line.
    logic ioLow; // I/O forced low while unpowered.
  } sys_t;

  // Card clock state.
  typedef struct packed {
    logic rstS1; // Reset synchroniser, first stage.
    logic rstS2; // Reset synchroniser, second stage.
    logic ceS1; // Enable synchroniser, first stage.
    logic ceS2; // Enable synchroniser, second stage.
    logic ioS1; // I/O synchroniser, first stage.
    logic ioS2; // I/O synchroniser, second stage.
    logic manS1; // Mode synchroniser, first stage.
    logic manS2; // Mode synchroniser, second stage.
    logic wenS1; // Wait enable synchroniser, first stage.
    logic wenS2; // Wait enable synchroniser, second stage.
    logic reqS1; // Transmit request toggle, first stage.
    logic reqS2; // Transmit request toggle, second stage.
    logic ldS1; // Load toggle, first stage.
    logic ldS2; // Load toggle, second stage.
    logic ioPrev; // Previous line level.
    logic wenPrev; // Previous wait enable.
    logic reqSeen; // Last request taken; also the acknowledge.
    logic ldSeen; // Last load handled.
    card_if_pkg::ser_state_t state; // Sequencer state.
    logic [ETU_W-1:0] etuCnt; // Time unit down counter.
    logic halfAlt; // Selects the short period.
    logic [3:0] bitCnt; // Slot within the frame.
    logic [7:0] shifter; // Shared shift register.
    logic [7:0] rxHold; // Received character for the system side.
    logic parAcc; // Running parity.
    logic [GUARD_W-1:0] guardCnt; // Units since last sent start edge.
    logic [23:0] waitCnt; // Waiting-time counter.
    logic waitRun; // Waiting counter running.
    logic locked; // Timeout lock.
    logic retry; // Resend pending.
    logic drive; // Pull the I/O line low.
    logic [card_if_pkg::CARD_EV_W-1:0] evBits; // Last events reported.
    logic evTog; // Event toggle.
  } card_t;

  sys_t sr;
  sys_t sn;
  card_t cr;
  card_t cn;

  // Last count of a time unit; the short period drops one cycle.
  function automatic logic [ETU_W-1:0] etuLast(input logic [ETU_W-1:0] n, input logic c, input logic a);
    etuLast = n - ETU_W'(1) - ETU_W'(c & a);
  endfunction

  // Shift one received bit into the register in the selected order.
  function automatic logic [7:0] shiftIn(input logic [7:0] s, input logic b, input logic m);
    shiftIn = m ? {s[6:0], b} : {b, s[7:1]};
  endfunction

  // Card-side logic: time base, sequencer and waiting counter.
  always_comb begin
    logic tick;
    logic rxBit;
    logic txBit;
    logic [card_if_pkg::CARD_EV_W-1:0] ev;
    tick = (cr.etuCnt == '0);
    rxBit = cr.ioS2 ^ invertData;
    txBit = msbFirst ? cr.shifter[7] : cr.shifter[0];
    ev = '0;
    cn = cr;
    if (cr.rstS2) begin
      // Block reset clears everything but the synchronisers and the guard counter, which is set full, so a timeout lock lifts too.
      cn = '0;
      cn.guardCnt = '1;
    end else if (cr.ceS2) begin
      cn.ioPrev = cr.ioS2;
      cn.wenPrev = cr.wenS2;
      // Free-running time unit counter; the tick is the shift enable.
      if (tick) begin
        cn.etuCnt = etuLast(etuValue, etuComp, cr.halfAlt);
        cn.halfAlt = ~cr.halfAlt;
      end else begin
        cn.etuCnt = cr.etuCnt - ETU_W'(1);
      end
      // Guard counter saturates so an idle line always allows sending.
      if (tick && cr.guardCnt != '1) begin
        cn.guardCnt = cr.guardCnt + GUARD_W'(1);
      end
      // Enable edges start and stop the waiting counter.
      if (cr.wenS2 && !cr.wenPrev) begin
        cn.waitRun = 1'b1;
      end else if (!cr.wenS2 && cr.wenPrev) begin
        cn.waitRun = 1'b0;
      end
      // Waiting counter counts units; reaching zero locks the block.
      if (tick && cr.waitRun && !cr.locked) begin
        if (cr.waitCnt <= 24'h00_0001) begin
          cn.waitCnt = '0;
          cn.locked = 1'b1;
          ev[card_if_pkg::EV_TIMEOUT] = 1'b1;
        end else begin
          cn.waitCnt = cr.waitCnt - 24'h00_0001;
        end
      end
      // A reload from the system side lifts a lock.
      if (cr.ldS2 != cr.ldSeen) begin
        cn.ldSeen = cr.ldS2;
        cn.waitCnt = {sr.waitTop, waitMid, waitLow};
        cn.locked = 1'b0;
      end
      case (cr.state)
        card_if_pkg::SER_IDLE: begin
          cn.drive = 1'b0;
          if (!cr.manS2 && !cr.locked) begin
            if ((cr.reqS2 != cr.reqSeen || cr.retry) && cr.guardCnt >= guardTime) begin
              // A resend reuses the shifter; a new character is loaded.
              if (!cr.retry) begin
                cn.shifter = sr.txBuf;
                cn.reqSeen = cr.reqS2;
              end
              cn.retry = 1'b0;
              cn.drive = 1'b1;
              cn.etuCnt = etuLast(etuValue, etuComp, cr.halfAlt);
              cn.bitCnt = card_if_pkg::SLOT_START;
              cn.guardCnt = '0;
              cn.parAcc = 1'b0;
              cn.waitCnt = {sr.waitTop, waitMid, waitLow};
              cn.state = card_if_pkg::SER_TX;
            end else if (cr.ioPrev && !cr.ioS2) begin
              // Half a unit later the tick falls mid start bit.
              cn.etuCnt = etuLast(etuValue, etuComp, cr.halfAlt) >> 1;
              cn.bitCnt = card_if_pkg::SLOT_START;
              cn.parAcc = 1'b0;
              cn.waitCnt = {sr.waitTop, waitMid, waitLow};
              cn.state = card_if_pkg::SER_RX;
            end
          end
        end
        card_if_pkg::SER_RX: begin
          if (tick) begin
            cn.bitCnt = cr.bitCnt + 4'h1;
            if (cr.bitCnt == card_if_pkg::SLOT_START) begin
              // A high line mid start bit was a glitch.
              if (cr.ioS2) begin
                cn.state = card_if_pkg::SER_IDLE;
              end
            end else if (cr.bitCnt == card_if_pkg::SLOT_PARITY) begin
              if (cr.parAcc ^ rxBit) begin
                ev[card_if_pkg::EV_PAR] = 1'b1;
                cn.state = card_if_pkg::SER_RXERR;
              end else begin
                ev[card_if_pkg::EV_RX] = 1'b1;
                cn.rxHold = cr.shifter;
                cn.state = card_if_pkg::SER_IDLE;
              end
            end else begin
              cn.shifter = shiftIn(cr.shifter, rxBit, msbFirst);
              cn.parAcc = cr.parAcc ^ rxBit;
            end
          end
        end
        card_if_pkg::SER_RXERR: begin
          // Error signal is one unit low from half past slot ten.
          if (tick) begin
            if (cr.bitCnt == card_if_pkg::SLOT_ERR) begin
              cn.drive = 1'b1;
              cn.bitCnt = cr.bitCnt + 4'h1;
            end else begin
              cn.drive = 1'b0;
              cn.state = card_if_pkg::SER_IDLE;
            end
          end
        end
        card_if_pkg::SER_TX: begin
          if (tick) begin
            cn.bitCnt = cr.bitCnt + 4'h1;
            if (cr.bitCnt < card_if_pkg::SLOT_DATA_END) begin
              // Rotating keeps the character whole after eight bits.
              cn.drive = ~(txBit ^ invertData);
              cn.parAcc = cr.parAcc ^ txBit;
              cn.shifter = msbFirst ? {cr.shifter[6:0], cr.shifter[7]} : {cr.shifter[0], cr.shifter[7:1]};
            end else if (cr.bitCnt == card_if_pkg::SLOT_DATA_END) begin
              cn.drive = ~(cr.parAcc ^ invertData);
            end else begin
              cn.drive = 1'b0;
              cn.state = card_if_pkg::SER_TXCHK;
            end
          end
        end
        card_if_pkg::SER_TXCHK: begin
          // The line is sampled one unit after the frame ends.
          if (tick) begin
            if (!cr.ioS2) begin
              cn.retry = 1'b1;
              ev[card_if_pkg::EV_REPEAT] = 1'b1;
            end else begin
              ev[card_if_pkg::EV_TX] = 1'b1;
            end
            cn.state = card_if_pkg::SER_IDLE;
          end
        end
        default: begin
          cn.state = card_if_pkg::SER_IDLE;
        end
      endcase
      // Manual mode or a lock abandons any character at once.
      if (cr.manS2 || cn.locked) begin
        cn.state = card_if_pkg::SER_IDLE;
        cn.drive = 1'b0;
      end
      // Events are posted with one toggle; they are units apart.
      if (|ev) begin
        cn.evBits = ev;
        cn.evTog = ~cr.evTog;
      end
    end
    // Synchronisers run regardless of reset and enable.
    cn.rstS1 = sr.blkRst;
    cn.rstS2 = cr.rstS1;
    cn.ceS1 = ce;
    cn.ceS2 = cr.ceS1;
    cn.ioS1 = ioIn;
    cn.ioS2 = cr.ioS1;
    cn.manS1 = manualMode;
    cn.manS2 = cr.manS1;
    cn.wenS1 = waitEnable;
    cn.wenS2 = cr.wenS1;
    cn.reqS1 = sr.txReq;
    cn.reqS2 = cr.reqS1;
    cn.ldS1 = sr.ldTog;
    cn.ldS2 = cr.ldS1;
  end

  // Card clock register.
  always_ff @(posedge cardClk) begin
    cr <= cn;
  end

  // System-side logic: buffers, events, interrupt and card power.
  always_comb begin
    logic present;
    logic [7:0] ev;
    present = presActiveHigh ? sr.presS2 : ~sr.presS2;
    ev = '0;
    sn = sr;
    sn.blkRst = rst | softReset;
    if (rst || softReset) begin
      sn = '0;
      sn.blkRst = 1'b1;
      sn.ioLow = 1'b1;
      sn.waitTop = card_if_pkg::WAIT_TOP_RESET;
    end else if (ce) begin
      sn.presS1 = cardPresentPin;
      sn.presS2 = sr.presS1;
      sn.ackS1 = cr.reqSeen;
      sn.ackS2 = sr.ackS1;
      sn.evS1 = cr.evTog;
      sn.evS2 = sr.evS1;
      sn.presPrev = present;
      // Presence edges become events.
      if (present && !sr.presPrev) begin
        ev[card_if_pkg::EV_INSERT] = 1'b1;
      end
      if (!present && sr.presPrev) begin
        ev[card_if_pkg::EV_REMOVE] = 1'b1;
      end
      // A read empties the buffer; an arriving character wins.
      if (rxRd) begin
        sn.rxValid = 1'b0;
      end
      if (sr.evS2 != sr.evSeen) begin
        sn.evSeen = sr.evS2;
        ev[card_if_pkg::CARD_EV_W-1:0] = cr.evBits;
        if (cr.evBits[card_if_pkg::EV_RX]) begin
          if (sr.rxValid && !rxRd) begin
            ev[card_if_pkg::EV_OVERRUN] = 1'b1;
          end
          sn.rxBuf = cr.rxHold;
          sn.rxValid = 1'b1;
        end
      end
      // The buffer frees when the card side echoes the request.
      if (sr.ackS2 == sr.txReq) begin
        sn.txFull = 1'b0;
      end
      if (txWr && !sn.txFull) begin
        sn.txBuf = txData;
        sn.txFull = 1'b1;
        sn.txReq = ~sr.txReq;
      end
      // Top byte write loads the counter only while disabled.
      if (waitTopWr) begin
        sn.waitTop = waitTopData;
        if (!waitEnable) begin
          sn.ldTog = ~sr.ldTog;
        end
      end
      // Events during a read are held and posted a cycle later.
      if (intRead) begin
        sn.intStatus = '0;
        sn.intPend = ev;
      end else begin
        sn.intStatus = sr.intStatus | sr.intPend | ev;
        sn.intPend = '0;
      end
      sn.irq = |(sn.intStatus & intEnable);
      case (sr.pwr)
        card_if_pkg::PWR_OFF: begin
          if (powerOnReq && present) begin
            sn.pwr = card_if_pkg::PWR_ON;
            sn.vccEn = 1'b1;
            sn.clkEn = 1'b1;
            sn.ioLow = 1'b0;
          end
        end
        card_if_pkg::PWR_ON: begin
          sn.rstLvl = cardResetCtl;
          // Removal starts the power-off sequence at once.
          if (!present || !powerOnReq) begin
            sn.pwr = card_if_pkg::PWR_DEACT;
            sn.stage = card_if_pkg::STAGE_RST;
            sn.stepCnt = '0;
            sn.rstLvl = 1'b0;
          end
        end
        card_if_pkg::PWR_DEACT: begin
          // Reset, clock, I/O, then supply, one step apart.
          if (sr.stepCnt == card_if_pkg::STEP_W'(card_if_pkg::DEACT_STEP_CYC - 1)) begin
            sn.stepCnt = '0;
            sn.stage = sr.stage + 2'h1;
            if (sr.stage == card_if_pkg::STAGE_RST) begin
              sn.clkEn = 1'b0;
            end else if (sr.stage == card_if_pkg::STAGE_CLK) begin
              sn.ioLow = 1'b1;
            end else if (sr.stage == card_if_pkg::STAGE_IO) begin
              sn.vccEn = 1'b0;
            end else begin
              sn.pwr = card_if_pkg::PWR_OFF;
            end
          end else begin
            sn.stepCnt = sr.stepCnt + card_if_pkg::STEP_W'(1);
          end
        end
        default: begin
          sn.pwr = card_if_pkg::PWR_OFF;
        end
      endcase
    end
  end

  // System clock register.
  always_ff @(posedge clk) begin
    sr <= sn;
  end

  // Outputs. The line is open drain, so only a low is ever driven.
  assign ioOut = 1'b0;
  assign ioOe = sr.ioLow | (manualMode ? ~manualIoValue : cr.drive);
  assign txFull = sr.txFull;
  assign rxData = sr.rxBuf;
  assign rxValid = sr.rxValid;
  assign intStatus = sr.intStatus;
  assign irq = sr.irq;
  assign cardVccEn = sr.vccEn;
  assign cardClkEn = sr.clkEn;
  assign cardResetOut = sr.rstLvl;

endmodule

/* File: shared/card_if_pkg.sv */
// Shared constants and types for the card character interface.
package card_if_pkg;

  // System clock rate and the deactivation step time derived from it.
  localparam int CLK_HZ = 10_000_000;
  localparam int DEACT_STEP_NS = 1000;
  localparam int DEACT_STEP_CYC = (DEACT_STEP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int STEP_W = $clog2(DEACT_STEP_CYC + 1);

  // Reset value of the top waiting-time byte.
  localparam logic [7:0] WAIT_TOP_RESET = 8'h00;

  // Bit slot indices inside one character frame.
  localparam logic [3:0] SLOT_START = 4'h0;
  localparam logic [3:0] SLOT_DATA_END = 4'h8;
  localparam logic [3:0] SLOT_PARITY = 4'h9;
  localparam logic [3:0] SLOT_ERR = 4'hA;

  // Positions of the event bits in the interrupt status byte.
  localparam int EV_RX = 0;
  localparam int EV_TX = 1;
  localparam int EV_PAR = 2;
  localparam int EV_REPEAT = 3;
  localparam int EV_TIMEOUT = 4;
  localparam int EV_INSERT = 5;
  localparam int EV_REMOVE = 6;
  localparam int EV_OVERRUN = 7;
  localparam int CARD_EV_W = 5;

  // Deactivation stages.
  localparam logic [1:0] STAGE_RST = 2'h0;
  localparam logic [1:0] STAGE_CLK = 2'h1;
  localparam logic [1:0] STAGE_IO = 2'h2;
  localparam logic [1:0] STAGE_VCC = 2'h3;

  // Character sequencer states.
  typedef enum logic [2:0] {
    SER_IDLE = 3'b000,
    SER_RX = 3'b001,
    SER_RXERR = 3'b010,
    SER_TX = 3'b011,
    SER_TXCHK = 3'b100
  } ser_state_t;

  // Card power states.
  typedef enum logic [1:0] {
    PWR_OFF = 2'b00,
    PWR_ON = 2'b01,
    PWR_DEACT = 2'b10
  } pwr_state_t;

endpackage

/* File: sim/card_if_checker.sv */
`timescale 1ns/1ps
// Watches the control side of the block; all timing is in system clocks.
module card_if_checker (
  input wire logic clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic ce, // Enable.
  input wire logic softReset, // Block reset.
  input wire logic txWr, // Tx write.
  input wire logic txFull, // Tx busy.
  input wire logic rxRd, // Rx read.
  input wire logic rxValid, // Rx ready.
  input wire logic intRead, // Status read.
  input wire logic [7:0] intEnable, // Mask.
  input wire logic [7:0] intStatus, // Flags.
  input wire logic irq, // Interrupt.
  input wire logic manualMode, // Manual.
  input wire logic manualIoValue, // Manual level.
  input wire logic ioOe, // Line pull.
  input wire logic presActiveHigh, // Polarity.
  input wire logic cardPresentPin, // Presence.
  input wire logic cardVccEn, // Supply.
  input wire logic cardClkEn, // Card clock.
  input wire logic cardResetOut // Card reset.
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst || softReset);
  // Removal with an active-high presence pin must bring the supply down within the step budget.
  sequence seqRemoved;
    $fell(cardPresentPin) && presActiveHigh;
  endsequence
  sequence seqSupplyOff;
    ##[1:60] !cardVccEn;
  endsequence
  AST_TXFULL_SET: assert property (txWr && ce && !txFull |=> txFull) else $error("txFull not set");
  AST_RXVALID_HOLD: assert property (rxValid && !rxRd |=> rxValid) else $error("rxValid lost");
  AST_IRQ_CAUSE: assert property ($rose(irq) |-> |(intStatus & intEnable)) else $error("irq no cause");
  AST_READ_CLEARS: assert property (intRead && ce |=> intStatus == 8'h00 && !irq) else $error("read no clear");
  AST_STICKY: assert property (!intRead |=> (intStatus & $past(intStatus)) == $past(intStatus)) else $error("flag lost");
  AST_MANUAL_IO: assert property ((manualMode && !manualIoValue) [*4] |-> ioOe) else $error("manual low");
  AST_REMOVE_DEACT: assert property (seqRemoved |-> seqSupplyOff) else $error("no power off");
  AST_DEACT_ORDER: assert property ($fell(cardVccEn) |-> !cardClkEn && !cardResetOut && ioOe) else $error("order");
endmodule
bind card_interface_block card_if_checker chk_u (.clk, .rst, .ce, .softReset, .txWr, .txFull, .rxRd, .rxValid,
  .intRead, .intEnable, .intStatus, .irq, .manualMode, .manualIoValue, .ioOe, .presActiveHigh, .cardPresentPin,
  .cardVccEn, .cardClkEn, .cardResetOut);

/* File: sim/card_model.sv */
`timescale 1ns/1ps
// Card side of the I/O line; it only ever pulls low, the pull-up does the rest.
module card_model #(
  parameter int UNIT = 8
) (
  input wire logic cardClk, // Card clock.
  input wire logic line, // Resolved line.
  output logic pull // High pulls low.
);
  logic [9:0] got; // Last frame seen, start at bit 0.
  logic errSeen; // Error signal seen after a sent frame.
  initial pull = 1'b0;
  // Whole units; the 1 ns step keeps changes off the sampling edge.
  task automatic units(input int n);
    repeat (n * UNIT) @(posedge cardClk);
    #1;
  endtask
  // Samples a frame mid-bit and may answer with the error signal.
  task automatic take(input bit nack);
    @(negedge line);
    repeat (UNIT / 2) @(posedge cardClk);
    for (int i = 0; i < 10; i++) begin
      got[i] = line;
      units(1);
    end
    pull = nack;
    units(1);
    pull = 1'b0;
  endtask
  // Sends ten line values, then looks for the error signal.
  task automatic send(input logic [9:0] bits);
    for (int i = 0; i < 10; i++) begin
      pull = !bits[i];
      units(1);
    end
    pull = 1'b0;
    units(1);
    errSeen = !line;
    units(1);
  endtask
endmodule

/* File: sim/smart_card_char_interface_test.sv */
`timescale 1ns/1ps
// Runs the block against the card model, one task per scenario.
module smart_card_char_interface_test;
  logic clk = 1'b0, cardClk = 1'b0, rst = 1'b1, softReset = 1'b0, manualMode = 1'b0, manualIoValue = 1'b1;
  logic ce = 1'b1, etuComp = 1'b0, presActiveHigh = 1'b1, ioOut;
  logic [10:0] etuValue = 11'h008; // Must match the card model's unit length.
  logic [8:0] guardTime = 9'h00C;
  logic invertData = 1'b0, msbFirst = 1'b0, waitEnable = 1'b0, waitTopWr = 1'b0, txWr = 1'b0, rxRd = 1'b0;
  logic intRead = 1'b0, powerOnReq = 1'b0, cardResetCtl = 1'b0, cardPresentPin = 1'b0, pull;
  logic [7:0] waitMid = 8'h00, waitLow = 8'h00, waitTopData = 8'h00, txData = 8'h00, intEnable = 8'h00;
  logic [7:0] rxData, intStatus;
  logic txFull, rxValid, irq, ioOe, cardVccEn, cardClkEn, cardResetOut;
  wire line = !(ioOe || pull); // Pulled up unless a party pulls low.
  int fails = 0, checked = 0, cycles = 0;
  always #50 clk = !clk;
  always #15 cardClk = !cardClk;
  card_interface_block #(.ETU_W(11), .GUARD_W(9)) dut_u (.clk, .rst, .ce, .cardClk, .softReset, .manualMode,
    .manualIoValue, .invertData, .msbFirst, .etuValue, .etuComp, .guardTime, .waitEnable,
    .waitMid, .waitLow, .waitTopWr, .waitTopData, .txWr, .txData, .txFull, .rxRd, .rxData, .rxValid, .intRead,
    .intEnable, .intStatus, .irq, .powerOnReq, .cardResetCtl, .presActiveHigh, .cardPresentPin,
    .ioIn(line), .ioOut, .ioOe, .cardVccEn, .cardClkEn, .cardResetOut);
  card_model #(.UNIT(8)) card_u (.cardClk, .line, .pull);
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // A hung handshake ends the run as a mismatch.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      finish_test;
    end
  end
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  // Bounded wait for one status flag.
  task automatic flag(input int b);
    @(negedge clk);
    for (int i = 0; i < 400 && intStatus[b] !== 1'b1; i++) @(negedge clk);
    check(intStatus[b], 1'b1);
  endtask
  // Direct convention: start, data low bit first, even parity.
  function automatic logic [9:0] frame(input logic [7:0] d);
    return {^d, d, 1'b0};
  endfunction
  // Inverse convention: high bit first and every data and parity value inverted.
  function automatic logic [9:0] inverse(input logic [7:0] d);
    logic [9:0] f;
    f[0] = 1'b0;
    for (int k = 0; k < 8; k++) f[k + 1] = !d[7 - k];
    f[9] = !(^d);
    return f;
  endfunction
  task automatic t_power;
    cardPresentPin = 1'b1;
    powerOnReq = 1'b1;
    flag(card_if_pkg::EV_INSERT);
    check(irq, 1'b0);
    intEnable = 8'hFF;
    repeat (2) @(negedge clk);
    check({irq, cardVccEn}, 2'b11);
    pulse(intRead);
    check({irq, intStatus}, 9'h000);
    cardResetCtl = 1'b1;
  endtask
  // A refused character is sent again from the shifter.
  task automatic t_tx(input logic [7:0] d, input bit nack);
    txData = d;
    fork
      begin
        card_u.take(nack);
        if (nack) card_u.take(1'b0);
      end
      pulse(txWr);
    join
    check(card_u.got, frame(d));
    flag(nack ? 3 : 1);
    check(txFull, 1'b0);
    pulse(intRead);
  endtask
  task automatic t_rx(input logic [9:0] bits, input logic [7:0] d, input bit bad);
    card_u.send(bits);
    check(card_u.errSeen, bad);
    flag(bad ? 2 : 0);
    check(rxValid, !bad);
    if (!bad) check(rxData, d);
    pulse(rxRd);
    pulse(intRead);
  endtask
  // Timeout locks the block; reload frees the held character.
  task automatic t_wait;
    waitLow = 8'h05;
    pulse(waitTopWr);
    waitEnable = 1'b1;
    flag(card_if_pkg::EV_TIMEOUT);
    txData = 8'h5A;
    pulse(txWr);
    repeat (60) @(negedge clk);
    check({txFull, line}, 2'b11);
    pulse(intRead);
    waitEnable = 1'b0;
    waitMid = 8'hFF;
    fork
      card_u.take(1'b0);
      pulse(waitTopWr);
    join
    check(card_u.got, frame(8'h5A));
  endtask
  task automatic t_manual;
    manualMode = 1'b1;
    manualIoValue = 1'b0;
    repeat (8) @(negedge clk);
    check(line, 1'b0);
    manualIoValue = 1'b1;
    repeat (8) @(negedge clk);
    check(line, 1'b1);
    check(ioOut, 1'b0);
    check(cardResetOut, 1'b1);
    manualMode = 1'b0;
    // A low enable freezes the block, so this write must not be taken.
    ce = 1'b0;
    txData = 8'h11;
    pulse(txWr);
    repeat (4) @(negedge clk);
    check(txFull, 1'b0);
    ce = 1'b1;
  endtask
  // Removal while powered must run the power-off steps; the block reset then clears the flags.
  task automatic t_remove;
    cardPresentPin = 1'b0;
    flag(card_if_pkg::EV_REMOVE);
    repeat (40) @(negedge clk);
    check({cardVccEn, cardClkEn, cardResetOut}, 3'b000);
    softReset = 1'b1;
    repeat (2) @(negedge clk);
    softReset = 1'b0;
    check(intStatus, 8'h00);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_power;
    t_tx(8'hA7, 1'b0);
    t_tx(8'h3C, 1'b1);
    {invertData, msbFirst} = 2'b11;
    t_rx(inverse(8'h3B), 8'h3B, 1'b0);
    {invertData, msbFirst} = 2'b00;
    t_rx(frame(8'h66) ^ 10'h200, 8'h66, 1'b1);
    t_wait;
    t_manual;
    t_remove;
    finish_test;
  end
endmodule
